// ===== rtl/ptc_regs.sv
// Test and 10M control register bank behind an AHB-Lite slave
// Operation
// - Bit 13 of the ten meg register lowers the 10M receive threshold.
// - Bits 12:9 pick the squelch level, 200mV at zero in 50mV steps.
// - Bit 7 set stops normal link pulses, clear sends them.
// - Bit 4 reads 1 after inverted receive polarity was seen.
// - Reading the ten meg register clears both polarity copies.
// - Bit 0 disables jabber protection, only while in 10M operation.
// - Self-test bits 15:8 count bytes the PRBS checker found in error.
// - Writing 1 to bit 15 locks the count for reads and clears the counter.
// - With counter mode 0 the error count stops at 0xff.
// - Self-test bits 7:0 hold the packet gap, reset value 0x7d.
// - Second self-test bits 10:0 hold packet length, reset 0x5ee.
// - Writing 1 to cable bit 15 starts a measurement.
// - The start bit clears when the done indication is set.
// - Done reads 1 once a measurement completed, and resets to 1.
// - Fail reads 1 when the measurement failed.
`timescale 1ns/1ps
module ptc_regs (
  input  wire logic                       clock_i,
  input  wire logic                       rst_b_i,
  input  wire logic                       hsel_i,
  input  wire logic [31:0]                haddr_i,
  input  wire logic [1:0]                 htrans_i,
  input  wire logic                       hwrite_i,
  input  wire logic [2:0]                 hsize_i,
  input  wire logic [31:0]                hwdata_i,
  input  wire logic                       hready_i,
  output logic      [31:0]                hrdata_o,
  output logic                            hreadyout_o,
  output logic                            hresp_o,
  input  wire logic                       pol_inverted_i,
  input  wire logic                       ten_meg_i,
  input  wire logic                       prbs_err_byte_i,
  input  wire logic                       err_cnt_mode_i,
  input  wire logic                       diag_done_i,
  input  wire logic                       diag_fail_i,
  output ptc_pkg::ptc_ten_meg_cfg_t       ten_meg_cfg_o,
  output logic                            pol_status_o,
  output ptc_pkg::ptc_selftest_cfg_t      selftest_cfg_o,
  output logic                            diag_start_o,
  output logic                            irq_o
);

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  function automatic logic hit(input logic [31:0] addr,
                               input logic [7:0]  idx);
    hit = (addr == {22'h0, idx, 2'h0});
  endfunction : hit

  logic                    dph_wr_q;
  logic [31:0]             dph_addr_q;
  logic                    pol_q;
  logic [7:0]              cnt_q;
  logic [7:0]              lock_q;
  logic                    start_q;
  logic                    done_q;
  logic                    fail_q;
  logic                    jab_q;
  logic [ptc_pkg::IRQ_W-1:0] sts_q;
  logic [ptc_pkg::IRQ_W-1:0] en_q;
  logic [ptc_pkg::IRQ_W-1:0] sts_set;
  logic [15:0]             rd_d;
  logic                    addr_ph;
  logic                    rd_tm;
  logic                    wr_tm;
  logic                    wr_st1;
  logic                    wr_st2;
  logic                    wr_cd;
  logic                    wr_clr;
  logic                    wr_en;
  logic                    lock_wr;
  logic                    done_evt;

  assign addr_ph  = hsel_i && hready_i && (htrans_i == ptc_pkg::HTRANS_NONSEQ);
  assign rd_tm    = addr_ph && !hwrite_i && hit(haddr_i, ptc_pkg::IDX_TEN_MEG);
  assign wr_tm    = dph_wr_q && hit(dph_addr_q, ptc_pkg::IDX_TEN_MEG);
  assign wr_st1   = dph_wr_q && hit(dph_addr_q, ptc_pkg::IDX_SELFTEST1);
  assign wr_st2   = dph_wr_q && hit(dph_addr_q, ptc_pkg::IDX_SELFTEST2);
  assign wr_cd    = dph_wr_q && hit(dph_addr_q, ptc_pkg::IDX_CABLE);
  assign wr_clr   = dph_wr_q && hit(dph_addr_q, ptc_pkg::IDX_IRQ_CLR);
  assign wr_en    = dph_wr_q && hit(dph_addr_q, ptc_pkg::IDX_IRQ_EN);
  assign lock_wr  = wr_st1 && hwdata_i[ptc_pkg::LOCK_BIT];
  assign done_evt = start_q && diag_done_i;

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      dph_wr_q    <= 1'b0;
      dph_addr_q  <= 32'h0;
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
    end else begin
      dph_wr_q    <= addr_ph && hwrite_i;
      dph_addr_q  <= haddr_i;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // Read data is formed in the address phase and stands in the data phase
  always_comb begin
    rd_d = 16'h0;
    if (hit(haddr_i, ptc_pkg::IDX_TEN_MEG)) begin
      rd_d[ptc_pkg::TM_LOWER_BIT] = ten_meg_cfg_o.lower_thresh;
      rd_d[ptc_pkg::TM_SQ_LSB +: 4] = ten_meg_cfg_o.squelch;
      rd_d[ptc_pkg::TM_NLP_BIT] = ten_meg_cfg_o.nlp_disable;
      rd_d[ptc_pkg::TM_POL_BIT] = pol_q;
      // Written jabber bit, not the speed-gated output
      rd_d[ptc_pkg::TM_JAB_BIT] = jab_q;
    end else if (hit(haddr_i, ptc_pkg::IDX_SELFTEST1)) begin
      rd_d = {lock_q, selftest_cfg_o.gap_len};
    end else if (hit(haddr_i, ptc_pkg::IDX_SELFTEST2)) begin
      rd_d = {5'h0, selftest_cfg_o.pkt_len};
    end else if (hit(haddr_i, ptc_pkg::IDX_CABLE)) begin
      // reserved field keeps its reset pattern
      rd_d = ptc_pkg::CABLE_RSVD;
      rd_d[ptc_pkg::DIAG_START_BIT] = start_q;
      rd_d[ptc_pkg::DIAG_DONE_BIT] = done_q;
      rd_d[ptc_pkg::DIAG_FAIL_BIT] = fail_q;
    end else if (hit(haddr_i, ptc_pkg::IDX_IRQ_STS)) begin
      rd_d = {13'h0, sts_q};
    end else if (hit(haddr_i, ptc_pkg::IDX_IRQ_EN)) begin
      rd_d = {13'h0, en_q};
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      hrdata_o <= 32'h0;
    end else if (addr_ph && !hwrite_i) begin
      hrdata_o <= {16'h0, rd_d};
    end
  end

  // Ten meg configuration; jabber disable leaves only in 10M operation
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      ten_meg_cfg_o.lower_thresh   <= 1'b0;
      ten_meg_cfg_o.squelch        <= ptc_pkg::SQ_RESET;
      ten_meg_cfg_o.nlp_disable    <= 1'b0;
      ten_meg_cfg_o.jabber_disable <= 1'b0;
    end else begin
      if (wr_tm) begin
        ten_meg_cfg_o.lower_thresh <= hwdata_i[ptc_pkg::TM_LOWER_BIT];
        ten_meg_cfg_o.squelch      <= hwdata_i[ptc_pkg::TM_SQ_LSB +: 4];
        ten_meg_cfg_o.nlp_disable  <= hwdata_i[ptc_pkg::TM_NLP_BIT];
      end
      ten_meg_cfg_o.jabber_disable <= (wr_tm ? hwdata_i[ptc_pkg::TM_JAB_BIT]
                                             : jab_q) && ten_meg_i;
    end
  end

  // Written jabber bit; reads return it whatever the speed
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      jab_q <= 1'b0;
    end else if (wr_tm) begin
      jab_q <= hwdata_i[ptc_pkg::TM_JAB_BIT];
    end
  end

  // Polarity status: detection wins over the clearing read
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pol_q <= 1'b0;
    end else if (pol_inverted_i) begin
      pol_q <= 1'b1;
    end else if (rd_tm) begin
      pol_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pol_status_o <= 1'b0;
    end else begin
      pol_status_o <= pol_inverted_i || (pol_q && !rd_tm);
    end
  end

  // Self-test configuration
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      selftest_cfg_o.gap_len <= ptc_pkg::GAP_RESET;
      selftest_cfg_o.pkt_len <= ptc_pkg::PKT_LEN_RESET;
    end else begin
      if (wr_st1) begin
        selftest_cfg_o.gap_len <= hwdata_i[7:0];
      end
      if (wr_st2) begin
        selftest_cfg_o.pkt_len <= hwdata_i[10:0];
      end
    end
  end

  // Error counter; an error byte in the lock cycle starts the new count
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      cnt_q  <= 8'h0;
      lock_q <= 8'h0;
    end else if (lock_wr) begin
      lock_q <= cnt_q;
      cnt_q  <= {7'h0, prbs_err_byte_i};
    end else if (prbs_err_byte_i) begin
      if (err_cnt_mode_i || cnt_q != ptc_pkg::ERR_CNT_MAX) begin
        cnt_q <= cnt_q + 8'h1;
      end
    end
  end

  // Cable diagnostics
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      start_q <= 1'b0;
      done_q  <= 1'b1;
      fail_q  <= 1'b0;
    end else if (done_evt) begin
      // start clears with done; a finished run beats a write
      start_q <= 1'b0;
      done_q  <= 1'b1;
      fail_q  <= diag_fail_i;
    end else if (wr_cd) begin
      start_q <= hwdata_i[ptc_pkg::DIAG_START_BIT];
      if (hwdata_i[ptc_pkg::DIAG_START_BIT]) begin
        done_q <= 1'b0;
        fail_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      diag_start_o <= 1'b0;
    end else begin
      diag_start_o <= !done_evt && (wr_cd ? hwdata_i[ptc_pkg::DIAG_START_BIT]
                                          : start_q);
    end
  end

  // Interrupt status: set wins over write-one-to-clear
  assign sts_set[ptc_pkg::IRQ_POL]  = pol_inverted_i && !pol_q;
  assign sts_set[ptc_pkg::IRQ_DONE] = done_evt;
  assign sts_set[ptc_pkg::IRQ_FAIL] = done_evt && diag_fail_i;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      sts_q <= '0;
      en_q  <= '0;
      irq_o <= 1'b0;
    end else begin
      sts_q <= sts_set | (sts_q & ~(wr_clr ? hwdata_i[ptc_pkg::IRQ_W-1:0]
                                           : {ptc_pkg::IRQ_W{1'b0}}));
      if (wr_en) begin
        en_q <= hwdata_i[ptc_pkg::IRQ_W-1:0];
      end
      irq_o <= |(sts_q & en_q);
    end
  end

  a_pol_read_clr: assert property (
    (rd_tm && !pol_inverted_i) |=> (!pol_q && !pol_status_o))
    else $error("polarity status not cleared by read");

  a_pol_sticky: assert property (
    pol_inverted_i |=> (pol_q ##1 (pol_q || $past(rd_tm))))
    else $error("polarity status lost");

  a_err_saturate: assert property (
    (cnt_q == 8'hff && !err_cnt_mode_i && !lock_wr) |=> cnt_q == 8'hff)
    else $error("error count left saturation");

  a_lock_count: assert property (
    (lock_wr && !prbs_err_byte_i) |=>
      (cnt_q == 8'h0 && lock_q == $past(cnt_q)))
    else $error("lock did not hold and clear count");

  a_diag_selfclr: assert property (
    done_evt |=> (!start_q && done_q && !diag_start_o))
    else $error("start not cleared with done");

  a_diag_running: assert property (
    start_q |-> !done_q)
    else $error("done high during measurement");

  a_jabber_gate: assert property (
    !ten_meg_i |=> !ten_meg_cfg_o.jabber_disable)
    else $error("jabber disable outside 10M");

  a_gap_write: assert property (
    wr_st1 |=> selftest_cfg_o.gap_len == $past(hwdata_i[7:0]))
    else $error("gap length not written");

  a_fail_capture: assert property (
    done_evt |=> (fail_q == $past(diag_fail_i))
                 ##1 ($stable(fail_q) || $past(wr_cd)))
    else $error("fail flag wrong after done");

  a_lower_write: assert property (
    wr_tm |=> ten_meg_cfg_o.lower_thresh
              == $past(hwdata_i[ptc_pkg::TM_LOWER_BIT]))
    else $error("lower threshold bit not written");

  a_squelch_write: assert property (
    wr_tm |=> ten_meg_cfg_o.squelch
              == $past(hwdata_i[ptc_pkg::TM_SQ_LSB +: 4]))
    else $error("squelch code not written");

  a_nlp_write: assert property (
    wr_tm |=> ten_meg_cfg_o.nlp_disable
              == $past(hwdata_i[ptc_pkg::TM_NLP_BIT]))
    else $error("link pulse control not written");

  a_pol_mirror: assert property (
    pol_status_o == pol_q)
    else $error("polarity copies differ");

  a_err_count: assert property (
    (prbs_err_byte_i && !lock_wr && cnt_q != 8'hff)
      |=> cnt_q == $past(cnt_q) + 8'h1)
    else $error("error byte not counted");

  a_pkt_write: assert property (
    wr_st2 |=> selftest_cfg_o.pkt_len == $past(hwdata_i[10:0]))
    else $error("packet length not written");

  a_start_write: assert property (
    (wr_cd && !done_evt) |=> (diag_start_o == start_q
      && start_q == $past(hwdata_i[ptc_pkg::DIAG_START_BIT])))
    else $error("start bit not written");

  a_upper_zero: assert property (
    hrdata_o[31:16] == 16'h0)
    else $error("upper read half not zero");

endmodule : ptc_regs

// ===== rtl/ptc_pkg.sv
// Shared constants and types of the PHY test and 10M control registers
package ptc_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0]  IDX_TEN_MEG   = 8'h1a;
  localparam logic [7:0]  IDX_SELFTEST1 = 8'h1b;
  localparam logic [7:0]  IDX_SELFTEST2 = 8'h1c;
  localparam logic [7:0]  IDX_CABLE     = 8'h1e;
  localparam logic [7:0]  IDX_IRQ_STS   = 8'h20;
  localparam logic [7:0]  IDX_IRQ_CLR   = 8'h21;
  localparam logic [7:0]  IDX_IRQ_EN    = 8'h22;

  // Ten meg register fields
  localparam int          TM_LOWER_BIT  = 13;
  localparam int          TM_SQ_LSB     = 9;
  localparam int          TM_NLP_BIT    = 7;
  localparam int          TM_POL_BIT    = 4;
  localparam int          TM_JAB_BIT    = 0;
  localparam logic [3:0]  SQ_RESET      = 4'h0;

  // Self-test fields
  localparam int          ERR_CNT_LSB   = 8;
  localparam int          LOCK_BIT      = 15;
  localparam logic [7:0]  ERR_CNT_MAX   = 8'hff;
  localparam logic [7:0]  GAP_RESET     = 8'h7d;
  localparam logic [10:0] PKT_LEN_RESET = 11'h5ee;

  // Cable diagnostic fields
  localparam int          DIAG_START_BIT = 15;
  localparam int          DIAG_DONE_BIT  = 1;
  localparam int          DIAG_FAIL_BIT  = 0;
  localparam logic [15:0] CABLE_RSVD     = 16'h0100;

  // Interrupt status bits
  localparam int          IRQ_POL       = 0;
  localparam int          IRQ_DONE      = 1;
  localparam int          IRQ_FAIL      = 2;
  localparam int          IRQ_W         = 3;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic       lower_thresh;
    logic [3:0] squelch;
    logic       nlp_disable;
    logic       jabber_disable;
  } ptc_ten_meg_cfg_t;

  typedef struct packed {
    logic [7:0]  gap_len;
    logic [10:0] pkt_len;
  } ptc_selftest_cfg_t;

endpackage : ptc_pkg

// ===== tb/tb.sv
// Self-checking bench for the test and 10M control register bank
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [7:0]  idx;
    logic [31:0] wd;
    logic [31:0] exp;
  } ptc_row_t;

  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [2:0]  hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic        pol_inverted_i = 1'b0;
  logic        ten_meg_i = 1'b1;
  logic        prbs_err_byte_i = 1'b0;
  logic        err_cnt_mode_i = 1'b0;
  logic        diag_done_i = 1'b0;
  logic        diag_fail_i = 1'b0;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  logic        pol_status_o;
  logic        diag_start_o;
  logic        irq_o;
  ptc_pkg::ptc_ten_meg_cfg_t  ten_meg_cfg_o;
  ptc_pkg::ptc_selftest_cfg_t selftest_cfg_o;
  int          num_errors = 0;
  int          check_count = 0;
  ptc_row_t    rst_rows [6];
  ptc_row_t    rows [8];

  always #12.5 clock_i = ~clock_i;

  ptc_regs DUT (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .pol_inverted_i(pol_inverted_i), .ten_meg_i(ten_meg_i),
    .prbs_err_byte_i(prbs_err_byte_i), .err_cnt_mode_i(err_cnt_mode_i),
    .diag_done_i(diag_done_i), .diag_fail_i(diag_fail_i),
    .ten_meg_cfg_o(ten_meg_cfg_o), .pol_status_o(pol_status_o),
    .selftest_cfg_o(selftest_cfg_o), .diag_start_o(diag_start_o),
    .irq_o(irq_o)
  );

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bounded wait for a ready edge; a hang ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 64);
    if (n >= 64) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel_i   <= 1'b1;
    htrans_i <= ptc_pkg::HTRANS_NONSEQ;
    haddr_i  <= {22'h0, idx, 2'h0};
    hwrite_i <= wr;
    wait_rdy();
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    wait_rdy();
    rd = hrdata_o;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, idx, wd, d);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, idx, 32'h0, d);
    chk(d, exp);
    chk({31'h0, hresp_o}, 32'h0);
  endtask : rd

  task automatic errs(input int n);
    repeat (n) begin
      prbs_err_byte_i <= 1'b1;
      @(posedge clock_i);
      prbs_err_byte_i <= 1'b0;
      @(posedge clock_i);
    end
  endtask : errs

  task automatic do_reset;
    rst_b_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    rst_b_i <= 1'b1;
    wait_rdy();
    chk({25'h0, ten_meg_cfg_o}, 32'h0);
    chk({13'h0, selftest_cfg_o}, {13'h0, 8'h7d, 11'h5ee});
    chk({30'h0, diag_start_o, irq_o}, 32'h0);
    foreach (rst_rows[i]) rd(rst_rows[i].idx, rst_rows[i].exp);
  endtask : do_reset

  task automatic diag(input logic fail);
    diag_fail_i <= fail;
    diag_done_i <= 1'b1;
    @(posedge clock_i);
    diag_done_i <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask : diag

  initial begin
    rst_rows = '{'{8'h1a, 0, 32'h0}, '{8'h1b, 0, 32'h7d},
                 '{8'h1c, 0, 32'h5ee}, '{8'h1e, 0, 32'h0102},
                 '{8'h20, 0, 32'h0}, '{8'h22, 0, 32'h0}};
    rows = '{'{8'h1a, 32'hfeff, 32'h3e81}, '{8'h1b, 32'h00a5, 32'h00a5},
             '{8'h1c, 32'hffff, 32'h07ff}, '{8'h1e, 32'h7fff, 32'h0102},
             '{8'h1d, 32'hffff, 32'h0}, '{8'h21, 32'hffff, 32'h0},
             '{8'h20, 32'hffff, 32'h0}, '{8'h22, 32'h0, 32'h0}};
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rd(rows[i].idx, rows[i].exp);
    end
    chk({25'h0, ten_meg_cfg_o}, 32'h7f);
    chk({13'h0, selftest_cfg_o}, {13'h0, 8'ha5, 11'h7ff});
    ten_meg_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk({25'h0, ten_meg_cfg_o}, 32'h7e);
    // Polarity seen while its interrupt is masked
    pol_inverted_i <= 1'b1;
    @(posedge clock_i);
    pol_inverted_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk({31'h0, pol_status_o}, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    rd(8'h20, 32'h1);
    wr(8'h22, 32'h7);
    repeat (2) @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h1);
    rd(8'h1a, 32'h3e91);
    chk({31'h0, pol_status_o}, 32'h0);
    rd(8'h1a, 32'h3e81);
    wr(8'h21, 32'h1);
    repeat (2) @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h0);
    // Error count saturates, then lock freezes it
    errs(300);
    wr(8'h1b, 32'h807d);
    rd(8'h1b, 32'hff7d);
    errs(3);
    rd(8'h1b, 32'hff7d);
    wr(8'h1b, 32'h807d);
    rd(8'h1b, 32'h037d);
    err_cnt_mode_i <= 1'b1;
    errs(258);
    wr(8'h1b, 32'h807d);
    rd(8'h1b, 32'h027d);
    // Cable measurement with and without failure
    wr(8'h1e, 32'h8000);
    @(posedge clock_i);
    chk({31'h0, diag_start_o}, 32'h1);
    rd(8'h1e, 32'h8100);
    diag(1'b1);
    chk({31'h0, diag_start_o}, 32'h0);
    rd(8'h1e, 32'h0103);
    rd(8'h20, 32'h6);
    chk({31'h0, irq_o}, 32'h1);
    wr(8'h21, 32'h6);
    repeat (2) @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h0);
    wr(8'h1e, 32'h8000);
    diag(1'b0);
    rd(8'h1e, 32'h0102);
    diag(1'b1);
    rd(8'h1e, 32'h0102);
    // Reset in mid-run restores every default
    do_reset();
    tally_and_finish();
  end
endmodule : tb
